//--- clk_gate_pkg.sv
package clk_gate_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [11:0] RUN_CLOCK_CONFIG_OFS      = 12'h060;
	localparam logic [11:0] RUN_PERIPHERAL_GATE_OFS   = 12'h104;
	localparam logic [11:0] SLEEP_PERIPHERAL_GATE_OFS = 12'h114;
	localparam logic [11:0] DEEP_SLEEP_PERIPHERAL_GATE_OFS = 12'h124;
	localparam logic [11:0] IRQ_STATUS_OFS            = 12'h200;
	localparam logic [11:0] IRQ_MASK_OFS              = 12'h204;

	// ****************************************
	// Field layout
	// ****************************************
	localparam int GP_COUNTER_UNIT0_POS = 16;
	localparam int SYNC_SERIAL_UNIT0_POS = 4;
	localparam int ASYNC_PORT0_POS      = 0;
	localparam int ANALOG_CMP_UNIT0_POS = 24;
	localparam int AUTO_GATING_SELECT_POS = 27;

	// Writable bits of every gate register; the rest read zero
	localparam logic [31:0] GATE_WRITABLE_MASK = 32'h070f_0013;
	localparam logic [31:0] RUN_CLOCK_CONFIG_MASK = 32'h0800_0000;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [31:0] GATE_RESET_VAL     = 32'h0000_0000;
	localparam logic [31:0] RUN_CLOCK_CONFIG_RESET = 32'h0000_0000;
	localparam logic [1:0]  IRQ_RESET_VAL      = 2'h0;

	// ****************************************
	// Interrupt status layout
	// ****************************************
	localparam int IRQ_GATED_ACCESS_POS = 0;
	localparam int IRQ_UNMAPPED_POS     = 1;

	// Unit numbering on the access port
	localparam int NUM_UNITS = 10;

	typedef enum logic [1:0] {
		PMODE_RUN,
		PMODE_SLEEP,
		PMODE_DEEP
	} power_mode_e;

endpackage

//--- peripheral_clock_gate_bank.sv
// Overview of operation
// - Bits 19:16 gate counter units 3..0
// - Bit 4 gates sync serial unit 0
// - Bits 1:0 gate async ports 1,0
// - Access to gated unit answers bus fault
// - All gate bits reset cleared
// - Separate run, sleep, deep-sleep gate registers
// - Sleep registers act only with auto gating
// - Reserved bits read zero, ignore writes
// - Deep-sleep register at 0x124, comparators 26:24
// - Absent unit positions behave as reserved
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps

module peripheral_clock_gate_bank #(
	parameter int UNITS = clk_gate_pkg::NUM_UNITS
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	input  wire logic        sleep_mode_i,
	input  wire logic        deep_mode_i,
	input  wire logic        periph_req_i,
	input  wire logic [3:0]  periph_unit_i,
	output logic             periph_ok_o,
	output logic             periph_fault_o,
	output logic [9:0]       unit_clk_en_o,
	output logic             irq_o
);

	// ****************************************
	// Unit index to gate bit position
	// ****************************************
	function automatic logic [4:0] unit_bit(input logic [3:0] unit);
		logic [4:0] pos;
		pos = 5'h1f;
		case (unit)
			4'h0: pos = 5'(clk_gate_pkg::ASYNC_PORT0_POS);
			4'h1: pos = 5'(clk_gate_pkg::ASYNC_PORT0_POS + 1);
			4'h2: pos = 5'(clk_gate_pkg::SYNC_SERIAL_UNIT0_POS);
			4'h3: pos = 5'(clk_gate_pkg::GP_COUNTER_UNIT0_POS);
			4'h4: pos = 5'(clk_gate_pkg::GP_COUNTER_UNIT0_POS + 1);
			4'h5: pos = 5'(clk_gate_pkg::GP_COUNTER_UNIT0_POS + 2);
			4'h6: pos = 5'(clk_gate_pkg::GP_COUNTER_UNIT0_POS + 3);
			4'h7: pos = 5'(clk_gate_pkg::ANALOG_CMP_UNIT0_POS);
			4'h8: pos = 5'(clk_gate_pkg::ANALOG_CMP_UNIT0_POS + 1);
			4'h9: pos = 5'(clk_gate_pkg::ANALOG_CMP_UNIT0_POS + 2);
			default: pos = 5'h1f;
		endcase
		return pos;
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	logic [31:0]               run_peripheral_gate_q;
	logic [31:0]               sleep_peripheral_gate_q;
	logic [31:0]               deep_sleep_peripheral_gate_q;
	logic                      auto_gating_select_q;
	logic [1:0]                irq_status_q;
	logic [1:0]                irq_status_d;
	logic [1:0]                irq_mask_q;
	logic [31:0]               eff_gate;
	logic [31:0]               rd_mux;
	logic                      hit_gate_run;
	logic                      hit_gate_sleep;
	logic                      hit_gate_deep;
	logic                      hit_cfg;
	logic                      hit_status;
	logic                      hit_mask;
	logic                      mapped;
	logic                      unit_enabled;
	clk_gate_pkg::power_mode_e mode;

	assign hit_gate_run   = addr_i == clk_gate_pkg::RUN_PERIPHERAL_GATE_OFS;
	assign hit_gate_sleep = addr_i == clk_gate_pkg::SLEEP_PERIPHERAL_GATE_OFS;
	assign hit_gate_deep  = addr_i == clk_gate_pkg::DEEP_SLEEP_PERIPHERAL_GATE_OFS;
	assign hit_cfg        = addr_i == clk_gate_pkg::RUN_CLOCK_CONFIG_OFS;
	assign hit_status     = addr_i == clk_gate_pkg::IRQ_STATUS_OFS;
	assign hit_mask       = addr_i == clk_gate_pkg::IRQ_MASK_OFS;
	assign mapped = hit_gate_run | hit_gate_sleep | hit_gate_deep | hit_cfg | hit_status | hit_mask;

	// Three independent gate registers, writable bits only
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			run_peripheral_gate_q <= clk_gate_pkg::GATE_RESET_VAL;
		end else if (ce_i && wr_i && hit_gate_run) begin
			run_peripheral_gate_q <= wdata_i & clk_gate_pkg::GATE_WRITABLE_MASK;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sleep_peripheral_gate_q <= clk_gate_pkg::GATE_RESET_VAL;
		end else if (ce_i && wr_i && hit_gate_sleep) begin
			sleep_peripheral_gate_q <= wdata_i & clk_gate_pkg::GATE_WRITABLE_MASK;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			deep_sleep_peripheral_gate_q <= clk_gate_pkg::GATE_RESET_VAL;
		end else if (ce_i && wr_i && hit_gate_deep) begin
			// Reserved and absent-unit positions are dropped here
			deep_sleep_peripheral_gate_q <= wdata_i & clk_gate_pkg::GATE_WRITABLE_MASK;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			auto_gating_select_q <= clk_gate_pkg::RUN_CLOCK_CONFIG_RESET[clk_gate_pkg::AUTO_GATING_SELECT_POS];
		end else if (ce_i && wr_i && hit_cfg) begin
			auto_gating_select_q <= wdata_i[clk_gate_pkg::AUTO_GATING_SELECT_POS];
		end
	end

	// ****************************************
	// Power mode selection
	// ****************************************
	always_comb begin
		if (deep_mode_i) begin
			mode = clk_gate_pkg::PMODE_DEEP;
		end else if (sleep_mode_i) begin
			mode = clk_gate_pkg::PMODE_SLEEP;
		end else begin
			mode = clk_gate_pkg::PMODE_RUN;
		end
	end

	always_comb begin
		eff_gate = run_peripheral_gate_q;
		if (auto_gating_select_q) begin
			case (mode)
				clk_gate_pkg::PMODE_SLEEP: eff_gate = sleep_peripheral_gate_q;
				clk_gate_pkg::PMODE_DEEP:  eff_gate = deep_sleep_peripheral_gate_q;
				default:                   eff_gate = run_peripheral_gate_q;
			endcase
		end
	end

	// Per-unit enables, one flop each
	generate
		for (genvar u = 0; u < UNITS; u++) begin : g_unit
			always_ff @(posedge mclk_i or posedge rst_i) begin
				if (rst_i) begin
					unit_clk_en_o[u] <= 1'b0;
				end else if (ce_i) begin
					unit_clk_en_o[u] <= eff_gate[unit_bit(4'(u))];
				end
			end
		end
	endgenerate

	// ****************************************
	// Peripheral access check
	// ****************************************
	// Unknown unit numbers land on bit 31, always zero, so they fault too
	assign unit_enabled = eff_gate[unit_bit(periph_unit_i)];

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			periph_ok_o    <= 1'b0;
			periph_fault_o <= 1'b0;
		end else if (ce_i) begin
			periph_ok_o    <= periph_req_i && unit_enabled;
			periph_fault_o <= periph_req_i && !unit_enabled;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_gate_run) begin
			rd_mux = run_peripheral_gate_q;
		end else if (hit_gate_sleep) begin
			rd_mux = sleep_peripheral_gate_q;
		end else if (hit_gate_deep) begin
			rd_mux = deep_sleep_peripheral_gate_q;
		end else if (hit_cfg) begin
			rd_mux = 32'({auto_gating_select_q}) << clk_gate_pkg::AUTO_GATING_SELECT_POS;
		end else if (hit_status) begin
			rd_mux = {30'h0, irq_status_q};
		end else if (hit_mask) begin
			rd_mux = {30'h0, irq_mask_q};
		end
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	// Set beats write-one-to-clear in the same cycle
	always_comb begin
		irq_status_d = irq_status_q;
		if (wr_i && hit_status) begin
			irq_status_d = irq_status_q & ~wdata_i[1:0];
		end
		if (periph_req_i && !unit_enabled) begin
			irq_status_d[clk_gate_pkg::IRQ_GATED_ACCESS_POS] = 1'b1;
		end
		if ((wr_i || rd_i) && !mapped) begin
			irq_status_d[clk_gate_pkg::IRQ_UNMAPPED_POS] = 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_status_q <= clk_gate_pkg::IRQ_RESET_VAL;
		end else if (ce_i) begin
			irq_status_q <= irq_status_d;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_mask_q <= clk_gate_pkg::IRQ_RESET_VAL;
		end else if (ce_i && wr_i && hit_mask) begin
			irq_mask_q <= wdata_i[1:0];
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= |(irq_status_d & irq_mask_q);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	logic first_q;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end

	sequence seq_gated_req;
		ce_i && periph_req_i && !unit_enabled;
	endsequence

	sequence seq_fault_answer;
		periph_fault_o && !periph_ok_o;
	endsequence

	sequence seq_deep_write;
		ce_i && wr_i && addr_i == clk_gate_pkg::DEEP_SLEEP_PERIPHERAL_GATE_OFS;
	endsequence

	AST_GATED_FAULT: assert property (@(posedge mclk_i) disable iff (rst_i)
		seq_gated_req |=> seq_fault_answer)
		else $error("access to gated unit not faulted");

	AST_CLOCKED_OK: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && periph_req_i && eff_gate[unit_bit(periph_unit_i)] |=> periph_ok_o && !periph_fault_o)
		else $error("access to clocked unit not answered normally");

	AST_RESET_CLEAR: assert property (@(posedge mclk_i) disable iff (rst_i)
		first_q |-> run_peripheral_gate_q == 32'h0 && sleep_peripheral_gate_q == 32'h0
			&& deep_sleep_peripheral_gate_q == 32'h0 && unit_clk_en_o == 10'h0)
		else $error("gate bits not cleared after reset");

	AST_DEEP_WRITE: assert property (@(posedge mclk_i) disable iff (rst_i)
		seq_deep_write |=> deep_sleep_peripheral_gate_q == ($past(wdata_i) & 32'h070f_0013))
		else $error("deep-sleep gate write wrong");

	AST_RESERVED_READ: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && rd_i && (hit_gate_run || hit_gate_sleep || hit_gate_deep)
			|=> (rdata_o & 32'hf8f0_ffec) == 32'h0)
		else $error("reserved gate bits read nonzero");

	AST_RUN_ONLY: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && !auto_gating_select_q |=> unit_clk_en_o[6:3] == $past(run_peripheral_gate_q[19:16]))
		else $error("sleep registers used without auto gating");

	AST_DEEP_SELECT: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && auto_gating_select_q && deep_mode_i
			|=> unit_clk_en_o[9:7] == $past(deep_sleep_peripheral_gate_q[26:24]))
		else $error("deep-sleep register not selected");

	AST_SLEEP_SELECT: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && auto_gating_select_q && sleep_mode_i && !deep_mode_i
			|=> unit_clk_en_o[2:0] == {$past(sleep_peripheral_gate_q[4]),
				$past(sleep_peripheral_gate_q[1:0])})
		else $error("sleep register not selected");

	AST_IRQ_RAISE: assert property (@(posedge mclk_i) disable iff (rst_i)
		seq_gated_req ##0 irq_mask_q[0] |=> irq_o ##1 (irq_status_q[0] || !ce_i))
		else $error("gated access did not raise interrupt");

endmodule

//--- peripheral_clock_gate_bank_tb.sv
`timescale 1ns/10ps

module peripheral_clock_gate_bank_tb;

	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic        mclk_i        = 1'b0;
	logic        rst_i         = 1'b1;
	logic        ce_i          = 1'b1;
	logic [11:0] addr_i        = 12'h000;
	logic [31:0] wdata_i       = 32'h0000_0000;
	logic        wr_i          = 1'b0;
	logic        rd_i          = 1'b0;
	logic        sleep_mode_i  = 1'b0;
	logic        deep_mode_i   = 1'b0;
	logic        periph_req_i  = 1'b0;
	logic [3:0]  periph_unit_i = 4'h0;
	logic [31:0] rdata_o;
	logic        periph_ok_o;
	logic        periph_fault_o;
	logic [9:0]  unit_clk_en_o;
	logic        irq_o;
	int          fails;
	int          cmp_count;
	logic [31:0] rv;
	logic [31:0] v;
	logic [31:0] gate_v [3];
	logic [11:0] ofs [4];
	logic [31:0] msk [4];
	logic        auto_gating_select;
	logic [9:0]  en;

	peripheral_clock_gate_bank i_peripheral_clock_gate_bank (
		.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_mode_i(sleep_mode_i),
		.deep_mode_i(deep_mode_i), .periph_req_i(periph_req_i),
		.periph_unit_i(periph_unit_i), .periph_ok_o(periph_ok_o),
		.periph_fault_o(periph_fault_o), .unit_clk_en_o(unit_clk_en_o), .irq_o(irq_o)
	);

	initial begin
		forever #12.5 mclk_i = ~mclk_i;
	end

	// ****************************************
	// Expectation helpers
	// ****************************************
	function automatic logic [9:0] gate_en(input logic [31:0] r);
		return {r[26:24], r[19:16], r[4], r[1:0]};
	endfunction

	// Auto gating off pins every mode to the run register
	function automatic logic [9:0] exp_en(input logic a, input logic s, input logic d);
		if (a && d) begin
			return gate_en(gate_v[2]);
		end
		if (a && s) begin
			return gate_en(gate_v[1]);
		end
		return gate_en(gate_v[0]);
	endfunction

	// ****************************************
	// Compare tasks
	// ****************************************
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_en(input logic [9:0] got, input logic [9:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: unit enables %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic [1:0] got, input logic [1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: flags %b, expected %b", $time, got, exp);
		end
	endtask

	// ****************************************
	// Bus tasks
	// ****************************************
	// Trailing idle edge keeps a strobe from being driven twice in one step
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		@(posedge mclk_i);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
		@(posedge mclk_i);
	endtask

	task automatic req(input logic [3:0] u, input logic ok);
		periph_unit_i <= u;
		periph_req_i <= 1'b1;
		@(posedge mclk_i);
		periph_req_i <= 1'b0;
		#1 chk_bit({periph_ok_o, periph_fault_o}, {ok, ~ok});
		@(posedge mclk_i);
	endtask

	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		v = $urandom(32'hf941);
		ofs = '{clk_gate_pkg::RUN_PERIPHERAL_GATE_OFS, clk_gate_pkg::SLEEP_PERIPHERAL_GATE_OFS,
			clk_gate_pkg::DEEP_SLEEP_PERIPHERAL_GATE_OFS, clk_gate_pkg::RUN_CLOCK_CONFIG_OFS};
		msk = '{clk_gate_pkg::GATE_WRITABLE_MASK, clk_gate_pkg::GATE_WRITABLE_MASK,
			clk_gate_pkg::GATE_WRITABLE_MASK, clk_gate_pkg::RUN_CLOCK_CONFIG_MASK};
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		for (int i = 0; i < 4; i++) begin
			rd(ofs[i], rv);
			chk_reg(rv, 32'h0000_0000);
		end
		#1 chk_en(unit_clk_en_o, 10'h000);
		@(posedge mclk_i);
		$display("test reset values done");
		for (int k = 0; k < 6; k++) begin
			for (int i = 0; i < 4; i++) begin
				v = (k == 0) ? 32'hffff_ffff : $urandom;
				wr(ofs[i], v);
				rd(ofs[i], rv);
				chk_reg(rv, v & msk[i]);
			end
		end
		$display("test register access done");
		for (int k = 0; k < 12; k++) begin
			for (int i = 0; i < 3; i++) begin
				gate_v[i] = $urandom & clk_gate_pkg::GATE_WRITABLE_MASK;
				wr(ofs[i], gate_v[i]);
			end
			auto_gating_select = k[0];
			sleep_mode_i <= k[1];
			deep_mode_i <= (k > 7) ? 1'b1 : 1'b0;
			wr(ofs[3], {4'h0, auto_gating_select, 27'h0});
			repeat (2) @(posedge mclk_i);
			en = exp_en(auto_gating_select, k[1], k > 7);
			#1 chk_en(unit_clk_en_o, en);
			@(posedge mclk_i);
			for (int u = 0; u < 16; u++) begin
				req(u[3:0], (u < 10) ? en[u] : 1'b0);
			end
		end
		$display("test gating and mode select done");
		wr(ofs[3], 32'h0000_0000);
		wr(ofs[0], 32'h0000_0001);
		wr(clk_gate_pkg::IRQ_STATUS_OFS, 32'h0000_0003);
		wr(clk_gate_pkg::IRQ_MASK_OFS, 32'h0000_0001);
		req(4'h0, 1'b1);
		#1 chk_bit({1'b0, irq_o}, 2'b00);
		@(posedge mclk_i);
		req(4'h3, 1'b0);
		#1 chk_bit({1'b0, irq_o}, 2'b01);
		@(posedge mclk_i);
		wr(clk_gate_pkg::IRQ_MASK_OFS, 32'h0000_0000);
		#1 chk_bit({1'b0, irq_o}, 2'b00);
		@(posedge mclk_i);
		rd(12'h300, rv);
		chk_reg(rv, 32'h0000_0000);
		rd(clk_gate_pkg::IRQ_STATUS_OFS, rv);
		chk_reg(rv, 32'h0000_0003);
		wr(clk_gate_pkg::IRQ_MASK_OFS, 32'h0000_0002);
		#1 chk_bit({1'b0, irq_o}, 2'b01);
		@(posedge mclk_i);
		wr(clk_gate_pkg::IRQ_STATUS_OFS, 32'h0000_0002);
		#1 chk_bit({1'b0, irq_o}, 2'b00);
		@(posedge mclk_i);
		rd(clk_gate_pkg::IRQ_STATUS_OFS, rv);
		chk_reg(rv, 32'h0000_0001);
		$display("test interrupt done");
		// Write while frozen must not land
		ce_i <= 1'b0;
		wr(ofs[0], 32'hffff_ffff);
		ce_i <= 1'b1;
		rd(ofs[0], rv);
		chk_reg(rv, 32'h0000_0001);
		$display("test clock enable freeze done");
		rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		#1 chk_en(unit_clk_en_o, 10'h000);
		chk_bit({periph_ok_o, irq_o}, 2'b00);
		@(posedge mclk_i);
		for (int i = 0; i < 4; i++) begin
			rd(ofs[i], rv);
			chk_reg(rv, 32'h0000_0000);
		end
		$display("test mid-run reset done");
		complete_run();
	end

	// Run needs well under 3000 cycles
	initial begin
		repeat (20000) @(posedge mclk_i);
		fails++;
		$display("unexpected at %0t: run did not finish", $time);
		complete_run();
	end

endmodule
